// ---- pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   output logic level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // Three stages, output follows once stages two and three agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level <= s3_q;
         end
      end
   end
endmodule : pin_sync
`default_nettype wire

// ---- vclk_phase.sv ----
`timescale 1ns/1ps
`default_nettype none
module vclk_phase #(
   parameter int POS_W = 9
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic restart,
   input wire logic run,
   input wire logic start_level,
   input wire logic [POS_W-1:0] first_pos,
   input wire logic [POS_W-1:0] second_pos,
   input wire logic [POS_W-1:0] pix_count,
   output logic level
);
   logic hit;

   // Either toggle position matches the pixel counter
   assign hit = (pix_count == first_pos) || (pix_count == second_pos);

   // Restart loads the start level, a hit flips the output
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         level <= 1'b0;
      end else if (restart) begin
         level <= start_level; // see (RULE2) see (RULE8)
      end else if (run && hit) begin
         level <= ~level; // see (RULE3) see (RULE4) see (RULE6)
      end
   end

   AST_TOGGLE_ON_HIT: assert property (@(posedge clk) disable iff (rst) // see (RULE3)
      (run && hit && !restart) |=> (level != $past(level)))
      else $error("output missed a toggle position");

   AST_RESTART_LEVEL: assert property (@(posedge clk) disable iff (rst) // see (RULE8)
      restart |=> (level == $past(start_level)))
      else $error("output did not return to its start level");

   AST_HOLD_OTHERWISE: assert property (@(posedge clk) disable iff (rst) // see (RULE4)
      (!restart && !(run && hit)) |=> $stable(level))
      else $error("output changed away from a toggle position");
endmodule : vclk_phase
`default_nettype wire

// ---- vert_pattern_gen.sv ----
// Summary of operation
// (RULE1) Four patterns, each driving all four outputs
// (RULE2) Start level bit: zero low, one high
// (RULE3) First toggle position, 9 bits, pixel counter
// (RULE4) Second toggle position, 9 bits, pixel counter
// (RULE5) Length sets pixels per repetition, counter restarts
// (RULE6) Positions count from current repetition start
// (RULE7) Repeat one gives one pulse, zero holds
// (RULE8) Each repetition starts at programmed start levels
`timescale 1ns/1ps
`default_nettype none
module vert_pattern_gen (
   input wire logic clk,
   input wire logic rst,
   input wire logic line_sync,
   input wire logic [1:0] pattern_sel,
   input wire logic [2:0] pattern_repeat_count,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_load_n,
   output logic ser_out,
   output logic vert_clock_out_1,
   output logic vert_clock_out_2,
   output logic vert_clock_out_3,
   output logic vert_clock_out_4
);
   localparam int NP = vpat_pkg::NUM_PAT;
   localparam int NO = vpat_pkg::NUM_OUT;
   localparam int PW = vpat_pkg::POS_W;

   // Serial port, filtered pins
   logic sck_f;
   logic sdi_f;
   logic sload_f;
   logic load_act;
   logic sck_prev_q;
   logic sload_prev_q;
   logic sck_rise;
   logic load_rise;
   logic [vpat_pkg::FRAME_BITS-1:0] shreg_q;
   logic [vpat_pkg::BITCNT_W-1:0] bits_q;
   logic [vpat_pkg::DATA_W-1:0] rd_q;
   logic wr_en;
   logic [6:0] wr_index;
   logic [vpat_pkg::DATA_W-1:0] wr_data;

   // Pattern storage
   logic [PW-1:0] len_q [NP];
   logic [NO-1:0] start_q [NP];
   logic [PW-1:0] pos_a_q [NP][NO];
   logic [PW-1:0] pos_b_q [NP][NO];

   // Pulse engine
   vpat_pkg::run_state_t state_q;
   logic [PW-1:0] cnt_q;
   logic [vpat_pkg::REP_W-1:0] reps_q;
   logic [vpat_pkg::SEL_W-1:0] pat_q;
   logic [PW-1:0] last_pix;
   logic running;
   logic wrap;
   logic restart;
   logic [NO-1:0] start_now;
   logic [NO-1:0] vout;

   pin_sync u_sync_sck (
      .clk(clk),
      .rst(rst),
      .pin(ser_clk),
      .level(sck_f)
   );

   pin_sync u_sync_sdi (
      .clk(clk),
      .rst(rst),
      .pin(ser_data),
      .level(sdi_f)
   );

   pin_sync u_sync_load (
      .clk(clk),
      .rst(rst),
      .pin(~ser_load_n),
      .level(load_act)
   );

   // Select synced inverted, so the reset level equals the idle high pin
   assign sload_f = ~load_act;

   // Edge detection on the filtered serial levels
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sck_prev_q <= 1'b0;
         sload_prev_q <= 1'b1;
      end else begin
         sck_prev_q <= sck_f;
         sload_prev_q <= sload_f;
      end
   end

   assign sck_rise = sck_f & ~sck_prev_q;
   assign load_rise = sload_f & ~sload_prev_q;

   // Shift register and bit counter, active while load is low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shreg_q <= '0;
         bits_q <= '0;
      end else if (sload_f) begin
         bits_q <= '0;
      end else if (sck_rise) begin
         shreg_q <= {shreg_q[vpat_pkg::FRAME_BITS-2:0], sdi_f};
         if (bits_q != vpat_pkg::BITS_FRAME_DONE) begin
            bits_q <= bits_q + 5'h01;
         end
      end
   end

   // Write commits only on a complete frame with the read flag clear
   assign wr_en = load_rise && (bits_q == vpat_pkg::BITS_FRAME_DONE)
                  && !shreg_q[vpat_pkg::FRAME_BITS-1];
   assign wr_index = shreg_q[vpat_pkg::FRAME_BITS-2:vpat_pkg::DATA_W];
   assign wr_data = shreg_q[vpat_pkg::DATA_W-1:0];

   // Register read mux by index
   function automatic logic [15:0] read_reg(input logic [6:0] idx);
      logic [15:0] val;
      logic [1:0] p;
      logic [3:0] f;
      logic [1:0] o;
      val = 16'h0000;
      p = idx[5:4];
      f = idx[3:0];
      o = 2'((f - vpat_pkg::FIELD_EDGE_BASE) >> 1);
      if (idx == vpat_pkg::STATUS_INDEX) begin
         val = {state_q, reps_q, pat_q, 1'b0, cnt_q};
      end else if (!idx[vpat_pkg::IDX_STATUS_BIT]) begin
         if (f == vpat_pkg::FIELD_LEN) begin
            val = {7'h00, len_q[p]};
         end else if (f == vpat_pkg::FIELD_START) begin
            val = {12'h000, start_q[p]};
         end else if (f <= vpat_pkg::FIELD_LAST) begin
            val = f[0] ? {7'h00, pos_b_q[p][o]} : {7'h00, pos_a_q[p][o]};
         end
      end
      return val;
   endfunction : read_reg

   // Read data loads after the address byte, then shifts MSB first
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_q <= '0;
      end else if (!sload_f && sck_rise) begin
         if ((bits_q == vpat_pkg::BITS_ADDR_DONE) && shreg_q[vpat_pkg::RD_FLAG_BIT]) begin
            rd_q <= read_reg(shreg_q[6:0]);
         end else begin
            rd_q <= {rd_q[vpat_pkg::DATA_W-2:0], 1'b0};
         end
      end
   end

   assign ser_out = rd_q[vpat_pkg::DATA_W-1];

   // Pattern registers, four independent sets
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NP; p++) begin
            len_q[p] <= vpat_pkg::RST_LEN;
            start_q[p] <= vpat_pkg::RST_START;
            for (int k = 0; k < NO; k++) begin
               pos_a_q[p][k] <= vpat_pkg::RST_POS;
               pos_b_q[p][k] <= vpat_pkg::RST_POS;
            end
         end
      end else if (wr_en && !wr_index[vpat_pkg::IDX_STATUS_BIT]) begin
         for (int p = 0; p < NP; p++) begin
            if (wr_index[5:4] == 2'(p)) begin // see (RULE1)
               if (wr_index[3:0] == vpat_pkg::FIELD_LEN) begin
                  len_q[p] <= wr_data[PW-1:0]; // see (RULE5)
               end
               if (wr_index[3:0] == vpat_pkg::FIELD_START) begin
                  start_q[p] <= wr_data[NO-1:0]; // see (RULE2)
               end
               for (int k = 0; k < NO; k++) begin
                  if (wr_index[3:0] == 4'(vpat_pkg::FIELD_EDGE_BASE + 4'(2 * k))) begin
                     pos_a_q[p][k] <= wr_data[PW-1:0]; // see (RULE3)
                  end
                  if (wr_index[3:0] == 4'(vpat_pkg::FIELD_EDGE_BASE + 4'(2 * k + 1))) begin
                     pos_b_q[p][k] <= wr_data[PW-1:0]; // see (RULE4)
                  end
               end
            end
         end
      end
   end

   // Last pixel of a repetition; a zero length acts as one pixel
   assign last_pix = (len_q[pat_q] == 9'h000) ? 9'h000 : len_q[pat_q] - 9'h001;
   assign running = (state_q == vpat_pkg::ST_RUN);
   assign wrap = running && (cnt_q == last_pix) && !line_sync;
   assign restart = line_sync || wrap;

   // Line start selects a pattern; repetitions counted down at each wrap
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= vpat_pkg::ST_IDLE;
         cnt_q <= vpat_pkg::RST_COUNT;
         reps_q <= '0;
         pat_q <= '0;
      end else if (line_sync) begin
         pat_q <= pattern_sel;
         reps_q <= pattern_repeat_count;
         cnt_q <= vpat_pkg::RST_COUNT;
         case (pattern_repeat_count)
            3'h0: state_q <= vpat_pkg::ST_IDLE; // see (RULE7)
            default: state_q <= vpat_pkg::ST_RUN;
         endcase
      end else begin
         case (state_q)
            vpat_pkg::ST_RUN: begin
               if (wrap) begin
                  cnt_q <= vpat_pkg::RST_COUNT; // see (RULE5) see (RULE6)
                  reps_q <= reps_q - 3'h1;
                  if (reps_q == 3'h1) begin
                     state_q <= vpat_pkg::ST_IDLE; // see (RULE7)
                  end
               end else begin
                  cnt_q <= cnt_q + 9'h001;
               end
            end
            vpat_pkg::ST_IDLE: begin
               cnt_q <= cnt_q;
            end
            default: state_q <= vpat_pkg::ST_IDLE;
         endcase
      end
   end

   // Start levels come from the new selection at line start
   assign start_now = line_sync ? start_q[pattern_sel] : start_q[pat_q];

   // One waveform generator per vertical output
   generate
      for (genvar k = 0; k < NO; k++) begin : g_out
         vclk_phase #(
            .POS_W(PW)
         ) u_phase (
            .clk(clk),
            .rst(rst),
            .restart(restart), // see (RULE8)
            .run(running), // see (RULE7)
            .start_level(start_now[k]),
            .first_pos(pos_a_q[pat_q][k]),
            .second_pos(pos_b_q[pat_q][k]),
            .pix_count(cnt_q),
            .level(vout[k])
         );
      end
   endgenerate

   assign vert_clock_out_1 = vout[0];
   assign vert_clock_out_2 = vout[1];
   assign vert_clock_out_3 = vout[2];
   assign vert_clock_out_4 = vout[3];

   AST_COUNT_STEP: assert property (@(posedge clk) disable iff (rst) // see (RULE6)
      (running && !line_sync && (cnt_q != last_pix)) |=> (cnt_q == $past(cnt_q) + 9'h001))
      else $error("pixel counter did not advance");

   AST_COUNT_WRAP: assert property (@(posedge clk) disable iff (rst) // see (RULE5)
      wrap |=> (cnt_q == 9'h000))
      else $error("pixel counter did not restart after the length");

   AST_ZERO_REPEAT_IDLE: assert property (@(posedge clk) disable iff (rst) // see (RULE7)
      (line_sync && (pattern_repeat_count == 3'h0)) |=> (state_q == vpat_pkg::ST_IDLE)
      ##0 (vout == $past(start_q[pattern_sel])))
      else $error("zero repeat did not hold the start levels");

   AST_IDLE_STABLE: assert property (@(posedge clk) disable iff (rst) // see (RULE7)
      (!running && !line_sync) |=> $stable(vout))
      else $error("outputs moved while no pattern runs");

   AST_SINGLE_PULSE_END: assert property (@(posedge clk) disable iff (rst) // see (RULE7)
      (wrap && (reps_q == 3'h1)) |=> (state_q == vpat_pkg::ST_IDLE))
      else $error("engine kept running after the last repetition");

   AST_WRAP_START_LEVEL: assert property (@(posedge clk) disable iff (rst) // see (RULE8)
      wrap |=> (vout == $past(start_q[pat_q])))
      else $error("outputs not at start levels on a new repetition");

   AST_LEN_WRITE: assert property (@(posedge clk) disable iff (rst) // see (RULE1)
      (wr_en && (wr_index == 7'h10)) |=> (len_q[1] == $past(wr_data[PW-1:0])))
      else $error("length write for the second pattern not stored");

   // Line start takes pattern, counter and start levels at once
   AST_SYNC_START_LEVEL: assert property (@(posedge clk) disable iff (rst) // see (RULE2)
      line_sync |=> (vout == $past(start_q[pattern_sel])))
      else $error("line start did not load the start levels");

   AST_SYNC_COUNT_CLEAR: assert property (@(posedge clk) disable iff (rst) // see (RULE6)
      line_sync |=> (cnt_q == 9'h000))
      else $error("line start did not clear the pixel counter");

   AST_SYNC_PATTERN: assert property (@(posedge clk) disable iff (rst) // see (RULE1)
      line_sync |=> (pat_q == $past(pattern_sel)))
      else $error("line start did not take the selected pattern");

   AST_SYNC_RUN: assert property (@(posedge clk) disable iff (rst) // see (RULE7)
      (line_sync && (pattern_repeat_count != 3'h0)) |=> running)
      else $error("nonzero repeat count did not start the engine");

   // Repetition bookkeeping
   AST_REPS_DOWN: assert property (@(posedge clk) disable iff (rst) // see (RULE7)
      (wrap && (reps_q != 3'h1)) |=> (reps_q == $past(reps_q) - 3'h1))
      else $error("repetition count not decremented at a wrap");

   AST_REPS_CONTINUE: assert property (@(posedge clk) disable iff (rst) // see (RULE5)
      (wrap && (reps_q != 3'h1)) |=> running)
      else $error("engine stopped before the last repetition");

   AST_IDLE_COUNT_HOLD: assert property (@(posedge clk) disable iff (rst) // see (RULE7)
      (!running && !line_sync) |=> $stable(cnt_q))
      else $error("pixel counter moved while no pattern runs");

   // Register writes land in the addressed set only
   AST_LEN0_WRITE: assert property (@(posedge clk) disable iff (rst) // see (RULE5)
      (wr_en && (wr_index == 7'h00)) |=> (len_q[0] == $past(wr_data[PW-1:0])))
      else $error("length write for the first pattern not stored");

   AST_START_WRITE: assert property (@(posedge clk) disable iff (rst) // see (RULE2)
      (wr_en && (wr_index == 7'h21)) |=> (start_q[2] == $past(wr_data[NO-1:0])))
      else $error("start level write for the third pattern not stored");

   AST_EDGE_A_WRITE: assert property (@(posedge clk) disable iff (rst) // see (RULE3)
      (wr_en && (wr_index == 7'h32)) |=> (pos_a_q[3][0] == $past(wr_data[PW-1:0])))
      else $error("first toggle position write not stored");

   AST_EDGE_A2_WRITE: assert property (@(posedge clk) disable iff (rst) // see (RULE3)
      (wr_en && (wr_index == 7'h16)) |=> (pos_a_q[1][2] == $past(wr_data[PW-1:0])))
      else $error("first toggle position write for output three not stored");

   AST_EDGE_B_WRITE: assert property (@(posedge clk) disable iff (rst) // see (RULE4)
      (wr_en && (wr_index == 7'h09)) |=> (pos_b_q[0][3] == $past(wr_data[PW-1:0])))
      else $error("second toggle position write not stored");

   AST_EDGE_B2_WRITE: assert property (@(posedge clk) disable iff (rst) // see (RULE4)
      (wr_en && (wr_index == 7'h25)) |=> (pos_b_q[2][1] == $past(wr_data[PW-1:0])))
      else $error("second toggle position write for output two not stored");
endmodule : vert_pattern_gen
`default_nettype wire

// ---- vert_pattern_gen_fix_note_unused.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- vertical_pulse_pattern_gen_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
   $display("BAD %s expected %h seen %h", what, exp, got); end end
module vertical_pulse_pattern_gen_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic line_sync = 1'b0;
   logic [1:0] pattern_sel = 2'h0;
   logic [2:0] pattern_repeat_count = 3'h0;
   logic ser_clk = 1'b0;
   logic ser_data = 1'b0;
   logic ser_load_n = 1'b1;
   wire logic ser_out;
   wire logic [3:0] vout;
   wire logic [15:0] edges;
   logic [3:0] expq[$];
   logic [3:0] want;
   logic [8:0] len_m[4];
   logic [3:0] st_m[4];
   logic [8:0] pa[4][4];
   logic [8:0] pb[4][4];
   logic [31:0] seed = 32'h0000433e;
   logic [15:0] d;
   int n_fail = 0;
   int checks_done = 0;

   // Pixel clock, 100 ns period
   always #50 clk = ~clk;

   vert_pattern_gen uut (.clk(clk), .rst(rst), .line_sync(line_sync),
      .pattern_sel(pattern_sel), .pattern_repeat_count(pattern_repeat_count),
      .ser_clk(ser_clk), .ser_data(ser_data), .ser_load_n(ser_load_n), .ser_out(ser_out),
      .vert_clock_out_1(vout[0]), .vert_clock_out_2(vout[1]),
      .vert_clock_out_3(vout[2]), .vert_clock_out_4(vout[3]));

   vsensor_model sensor (.phase_1(vout[0]), .phase_2(vout[1]), .phase_3(vout[2]),
      .phase_4(vout[3]), .edges(edges));

   // Xorshift source for positions and noise
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // Serial frame, each pin level held 6 clocks to clear the sync filter
   task automatic ser_frame(input logic [23:0] frame, input int nbits, output logic [15:0] rd);
      rd = 16'h0000;
      ser_load_n <= 1'b0;
      cyc(6);
      for (int k = 1; k <= nbits + 1; k++) begin
         ser_clk <= 1'b0;
         if (k <= nbits) ser_data <= frame[24 - k];
         cyc(6);
         if (k >= 10) rd = {rd[14:0], ser_out};
         if (k <= nbits) begin
            ser_clk <= 1'b1;
            cyc(6);
         end
      end
      ser_load_n <= 1'b1;
      cyc(8);
   endtask : ser_frame

   task automatic wr(input logic [6:0] idx, input logic [15:0] data);
      logic [15:0] junk;
      ser_frame({1'b0, idx, data}, 24, junk);
   endtask : wr

   task automatic rd_reg(input logic [6:0] idx, output logic [15:0] data);
      ser_frame({1'b1, idx, 16'(rnd())}, 24, data);
   endtask : rd_reg

   // Program one pattern with random fields, plus last-pixel and out-of-range edges
   task automatic prog(input int p);
      logic [15:0] r;
      len_m[p] = 9'(rnd() % 40) + 9'h002;
      st_m[p] = 4'(rnd());
      wr({1'b0, 2'(p), 4'h0}, {7'h00, len_m[p]});
      wr({1'b0, 2'(p), 4'h1}, {12'h000, st_m[p]});
      for (int o = 0; o < 4; o++) begin
         pa[p][o] = 9'(rnd() % (len_m[p] + 9'h002));
         pb[p][o] = 9'(rnd() % (len_m[p] + 9'h002));
         if (o == 0) pb[p][o] = len_m[p] - 9'h001;
         if (o == 1) pa[p][o] = len_m[p];
         wr({1'b0, 2'(p), 4'(2 + 2 * o)}, {7'h00, pa[p][o]});
         wr({1'b0, 2'(p), 4'(3 + 2 * o)}, {7'h00, pb[p][o]});
      end
      rd_reg({1'b0, 2'(p), 4'h0}, r);
      `CHK("length", len_m[p], r[8:0])
      rd_reg({1'b0, 2'(p), 4'h1}, r);
      `CHK("start levels", st_m[p], r[3:0])
      rd_reg({1'b0, 2'(p), 4'h9}, r);
      `CHK("second edge", pb[p][3], r[8:0])
   endtask : prog

   // Start a line and queue the expected level of every following cycle
   task automatic run_line(input int p, input logic [2:0] rep);
      logic [8:0] len;
      logic [8:0] cnt;
      logic [3:0] o;
      logic [3:0] nx;
      logic [2:0] left;
      int e;
      logic [15:0] e0;
      pattern_sel <= 2'(p);
      pattern_repeat_count <= rep;
      line_sync <= 1'b1;
      @(posedge clk);
      line_sync <= 1'b0;
      pattern_sel <= 2'(rnd());
      pattern_repeat_count <= 3'(rnd());
      len = (len_m[p] == 9'h000) ? 9'h001 : len_m[p];
      cnt = 9'h000;
      o = st_m[p];
      left = rep;
      e = 0;
      for (int c = 0; c < rep * len + 4; c++) begin
         expq.push_back(o);
         if (left != 3'h0) begin
            nx = o;
            for (int i = 0; i < 4; i++) begin
               if (cnt == pa[p][i] || cnt == pb[p][i]) nx[i] = ~nx[i];
            end
            if (cnt == len - 9'h001) begin
               nx = st_m[p];
               cnt = 9'h000;
               left--;
            end else begin
               cnt++;
            end
            e += $countones(nx ^ o);
            o = nx;
         end
      end
      @(negedge clk);
      e0 = edges;
      while (expq.size() != 0) @(negedge clk);
      @(negedge clk);
      `CHK("sensor edge count", 16'(e), edges - e0)
      @(posedge clk);
   endtask : run_line

   // Output watcher: one queued level per cycle
   always @(negedge clk) begin
      if (expq.size() != 0) begin
         want = expq.pop_front();
         `CHK("vert outputs", want, vout)
      end
   end

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   // Main sequence
   initial begin
      cyc(20);
      rst <= 1'b0;
      cyc(8);
      rd_reg(7'h12, d);
      `CHK("reset value", 9'h000, d[8:0])
      for (int p = 0; p < 4; p++) prog(p);
      run_line(0, 3'h1);
      run_line(1, 3'h0);
      run_line(2, 3'h2);
      run_line(3, 3'h7);
      rd_reg(7'h40, d);
      `CHK("status", 16'h0c00, d)
      ser_frame({1'b0, 7'h00, 16'h01ff}, 23, d);
      rd_reg(7'h00, d);
      `CHK("short frame", len_m[0], d[8:0])
      for (int n = 0; n < 6; n++) run_line(int'(rnd() % 4), 3'(rnd()));
      close_out();
   end

   // Watchdog against a hung handshake
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      $display("BAD watchdog expected finish seen timeout");
      close_out();
   end
endmodule : vertical_pulse_pattern_gen_tb_top
`default_nettype wire

// ---- vpat_pkg.sv ----
`default_nettype none
package vpat_pkg;
   // Pattern and output counts, field widths
   localparam int NUM_PAT = 4;
   localparam int NUM_OUT = 4;
   localparam int POS_W = 9;
   localparam int REP_W = 3;
   localparam int SEL_W = 2;

   // Serial frame: read flag, 7-bit index, 16-bit data, MSB first
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int FRAME_BITS = 24;
   localparam int BITCNT_W = 5;
   localparam logic [4:0] BITS_ADDR_DONE = 5'h08;
   localparam logic [4:0] BITS_FRAME_DONE = 5'h18;
   localparam int RD_FLAG_BIT = 7;

   // Register index: bit 6 status space, bits 5:4 pattern, bits 3:0 field
   localparam logic [6:0] STATUS_INDEX = 7'h40;
   localparam int IDX_STATUS_BIT = 6;
   localparam logic [3:0] FIELD_LEN = 4'h0;
   localparam logic [3:0] FIELD_START = 4'h1;
   localparam logic [3:0] FIELD_EDGE_BASE = 4'h2;
   localparam logic [3:0] FIELD_LAST = 4'h9;

   // Values after reset
   localparam logic [8:0] RST_LEN = 9'h000;
   localparam logic [3:0] RST_START = 4'h0;
   localparam logic [8:0] RST_POS = 9'h000;
   localparam logic [8:0] RST_COUNT = 9'h000;

   // Pulse engine state
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } run_state_t;
endpackage : vpat_pkg
`default_nettype wire

// ---- vsensor_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module vsensor_model (
   input wire logic phase_1,
   input wire logic phase_2,
   input wire logic phase_3,
   input wire logic phase_4,
   output logic [15:0] edges
);
   int n1 = 0;
   int n2 = 0;
   int n3 = 0;
   int n4 = 0;

   // One counter per transfer gate, so simultaneous changes are never merged
   always @(phase_1) n1 = n1 + 1;
   always @(phase_2) n2 = n2 + 1;
   always @(phase_3) n3 = n3 + 1;
   always @(phase_4) n4 = n4 + 1;

   // Total level changes seen by the sensor
   assign edges = 16'(n1 + n2 + n3 + n4);
endmodule : vsensor_model
`default_nettype wire
